// ==== hdl/amp_regs_pkg.sv ====
// shared constants and carriers for the amplifier mode and power register bank
package amp_regs_pkg;

   // register offsets within the selected page
   localparam logic [7:0] PAGE_SEL_ADDR  = 8'h00;
   localparam logic [7:0] MODE_CTRL_ADDR = 8'h02;
   localparam logic [7:0] SPEAKER_CONTROL_ADDR  = 8'h04;
   localparam logic [7:0] PWR_AUX_ADDR   = 8'h05;
   localparam logic [7:0] PWR_STATE_ADDR = 8'h07;
   localparam logic [7:0] LAST_ADDR      = 8'h7f;

   // page holding this bank
   localparam logic [7:0] BANK_PAGE = 8'h00;

   // reset values
   localparam logic [7:0] PAGE_SEL_RST  = 8'h00;
   localparam logic [7:0] MODE_CTRL_RST = 8'h01;
   localparam logic [7:0] SPEAKER_CONTROL_RST  = 8'h5f;
   localparam logic [7:0] PWR_AUX_RST   = 8'h00;
   localparam logic [7:0] PWR_STATE_RST = 8'h00;

   // field positions
   localparam int AUTO_INC_BIT    = 7;
   localparam int PATH_MODE_LSB   = 0;
   localparam int PATH_MODE_MSB   = 2;
   localparam int OFF_DLY_LSB     = 6;
   localparam int OFF_DLY_MSB     = 7;
   localparam int PRECHARGE_BIT   = 5;
   localparam int RAIL_SCHEME_BIT = 4;
   localparam int GAIN_LSB        = 0;
   localparam int GAIN_MSB        = 3;
   localparam int FAULT_FLAG_BIT  = 0;
   localparam int PWR_SEL_LSB     = 6;
   localparam int PWR_SEL_MSB     = 7;
   localparam int ISNS_MUTE_BIT   = 2;
   localparam int VSNS_MUTE_BIT   = 1;
   localparam int AUDIO_MUTE_BIT  = 0;

   // pop-free mute ramp: one gain step per this many cycles
   localparam logic [7:0] MUTE_STEP_CYCLES = 8'h40;

   // audio path modes
   typedef enum logic [2:0] {
      PATH_RSVD0   = 3'h0,
      PATH_PCM     = 3'h1,
      PATH_PCM_PCM = 3'h2,
      PATH_PCM_PDM = 3'h3,
      PATH_PDM     = 3'h4,
      PATH_PDM_PDM = 3'h5,
      PATH_RSVD6   = 3'h6,
      PATH_RSVD7   = 3'h7
   } path_mode_e;

   // device power states
   typedef enum logic [1:0] {
      PWR_DOWN     = 2'h0,
      PWR_UP_BOOST = 2'h1,
      PWR_UP_NOBST = 2'h2,
      PWR_RSVD     = 2'h3
   } power_state_e;

   // playback ramp fsm, gray along idle -> fade -> silent
   typedef enum logic [1:0] {
      RAMP_OPEN   = 2'h0,
      RAMP_FADE   = 2'h1,
      RAMP_SILENT = 2'h3,
      RAMP_RISE   = 2'h2
   } ramp_state_e;

   // register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // decoded controls toward the analog and audio paths
   typedef struct packed {
      path_mode_e   path_mode;
      logic         pcm_in;
      logic         pdm_in;
      logic         pcm_sense;
      logic         pdm_sense;
      logic         boost_on;
      logic         boost_to_max;
      logic         boost_track;
      logic [1:0]   boost_off_delay;
      logic         boost_precharge;
      logic [3:0]   dac_gain_db;
      logic         powered;
      logic         current_sense_silence;
      logic         voltage_sense_silence;
   } amp_ctrl_s;

endpackage

// ==== hdl/amp_reg_store.sv ====
// small byte store for the bank registers with registered read data
`timescale 1ns/1ps
module amp_reg_store (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   // write side, one entry per cycle
   input  wire logic       wr_en_i,
   input  wire logic [1:0] wr_idx_i,
   input  wire logic [7:0] wr_data_i,
   // read side
   input  wire logic [1:0] rd_idx_i,
   output logic [7:0]      rd_data_o,
   // all entries, for decode
   output logic [31:0]     all_o
);

   logic [7:0] mem_r [4];

   // per entry storage with its own reset value
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ent
         localparam logic [7:0] RST = (g == 0) ? amp_regs_pkg::MODE_CTRL_RST :
                                      (g == 1) ? amp_regs_pkg::SPEAKER_CONTROL_RST :
                                      (g == 2) ? amp_regs_pkg::PWR_AUX_RST :
                                                 amp_regs_pkg::PWR_STATE_RST;
         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               mem_r[g] <= RST;
            end else if (wr_en_i && wr_idx_i == 2'(g)) begin
               mem_r[g] <= wr_data_i;
            end
         end
         assign all_o[g*8 +: 8] = mem_r[g];
      end
   endgenerate

   // registered read port
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= mem_r[rd_idx_i];
      end
   end

endmodule

// ==== hdl/amp_mode_power_control_regs.sv ====
// mode, speaker and power register bank of the boosted mono amplifier
`timescale 1ns/1ps
module amp_mode_power_control_regs (
   // clock and reset
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_i,
   // register access port
   input  wire amp_regs_pkg::reg_req_s  req_i,
   output logic [7:0]                   rdata_o,
   output logic                         rvalid_o,
   // fault detection from protection logic
   input  wire logic                    fault_i,
   // decoded controls
   output amp_regs_pkg::amp_ctrl_s      ctrl_o,
   output logic [3:0]                   play_atten_o,
   output logic                         play_muted_o,
   output logic                         page_auto_increment_o,
   output logic [7:0]                   page_o,
   output logic                         soft_reset_o
);

   ////////////////////////////////////////////////////////////////////////
   // page select and address map

   logic [7:0]  page_r;
   logic [31:0] regs;
   logic [7:0]  mode_q;
   logic [7:0]  spk_q;
   logic [7:0]  aux_q;
   logic [7:0]  pwr_q;
   logic        on_page;
   logic        hit;
   logic [1:0]  idx;
   logic        st_wr;
   logic [7:0]  st_data;
   logic [1:0]  st_widx;
   logic        fault_d_r;
   logic        fault_rise;

   assign mode_q = regs[7:0];
   assign spk_q  = regs[15:8];
   assign aux_q  = regs[23:16];
   assign pwr_q  = regs[31:24];

   assign on_page = (page_r == amp_regs_pkg::BANK_PAGE);

   // map offset onto the store index
   always_comb begin
      hit = on_page;
      idx = 2'h0;
      case (req_i.addr)
         amp_regs_pkg::MODE_CTRL_ADDR: idx = 2'h0;
         amp_regs_pkg::SPEAKER_CONTROL_ADDR:  idx = 2'h1;
         amp_regs_pkg::PWR_AUX_ADDR:   idx = 2'h2;
         amp_regs_pkg::PWR_STATE_ADDR: idx = 2'h3;
         default:                      hit = 1'b0;
      endcase
   end

   // page register lives in every page so software can always leave
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         page_r <= amp_regs_pkg::PAGE_SEL_RST;
      end else if (req_i.wr && req_i.addr == amp_regs_pkg::PAGE_SEL_ADDR) begin
         page_r <= req_i.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write path, fault updates merged into the same store write

   assign fault_rise = fault_i & ~fault_d_r;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fault_d_r <= 1'b0;
      end else begin
         fault_d_r <= fault_i;
      end
   end

   // one write port: a fault outranks a host write in the same cycle
   always_comb begin
      st_wr   = 1'b0;
      st_widx = idx;
      st_data = req_i.wdata;
      if (fault_rise) begin
         st_wr   = 1'b1;
         st_widx = 2'h3;
         st_data = pwr_q;
         if (req_i.wr && hit && idx == 2'h3) begin
            st_data = req_i.wdata;
         end
         st_data[amp_regs_pkg::PWR_SEL_MSB:amp_regs_pkg::PWR_SEL_LSB] = amp_regs_pkg::PWR_DOWN;
      end else if (req_i.wr && hit) begin
         st_wr = 1'b1;
         if (idx == 2'h0) begin
            st_data[amp_regs_pkg::AUTO_INC_BIT] = 1'b0; // reset request never sticks
         end
      end
   end

   amp_reg_store u_store (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (st_wr),
      .wr_idx_i  (st_widx),
      .wr_data_i (st_data),
      .rd_idx_i  (idx),
      .rd_data_o (),
      .all_o     (regs)
   );

   ////////////////////////////////////////////////////////////////////////
   // error flag: fault sets, host write of zero clears, set wins

   logic err_r;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         err_r <= amp_regs_pkg::PWR_AUX_RST[amp_regs_pkg::FAULT_FLAG_BIT];
      end else if (fault_i) begin
         err_r <= 1'b1;
      end else if (req_i.wr && hit && idx == 2'h2) begin
         err_r <= req_i.wdata[amp_regs_pkg::FAULT_FLAG_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software reset pulse and auto increment enable

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         soft_reset_o <= 1'b0;
      end else begin
         soft_reset_o <= req_i.wr && hit && idx == 2'h0 && req_i.wdata[amp_regs_pkg::AUTO_INC_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         page_auto_increment_o <= 1'b1;
         page_o                <= amp_regs_pkg::PAGE_SEL_RST;
      end else begin
         page_auto_increment_o <= ~mode_q[amp_regs_pkg::AUTO_INC_BIT]; // clear means enabled
         page_o                <= page_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, data one cycle after the request, straight from flops

   logic [7:0] map_rdata;

   // sticky error flag replaces the stored bit so a read shows a fault until the host clears it
   always_comb begin
      case (idx)
         2'h0:    map_rdata = mode_q;
         2'h1:    map_rdata = spk_q;
         2'h2:    map_rdata = {aux_q[7:1], err_r};
         default: map_rdata = pwr_q;
      endcase
   end

   // unmapped offsets and other pages read zero, except the page select at offset 0, which reads back on every page
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= 8'h00;
      end else begin
         rvalid_o <= req_i.rd;
         if (req_i.rd && req_i.addr == amp_regs_pkg::PAGE_SEL_ADDR) begin
            rdata_o <= page_r;
         end else if (req_i.rd && hit) begin
            rdata_o <= map_rdata;
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pop-free playback mute: gain walks down one step at a time

   amp_regs_pkg::ramp_state_e ramp_r;
   logic [7:0] step_cnt_r;
   logic       mute_req;

   assign mute_req = pwr_q[amp_regs_pkg::AUDIO_MUTE_BIT] ||
                     pwr_q[amp_regs_pkg::PWR_SEL_MSB:amp_regs_pkg::PWR_SEL_LSB] == amp_regs_pkg::PWR_DOWN;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ramp_r       <= amp_regs_pkg::RAMP_SILENT;
         step_cnt_r   <= 8'h00;
         play_atten_o <= 4'hf;
         play_muted_o <= 1'b1;
      end else begin
         step_cnt_r <= (step_cnt_r == amp_regs_pkg::MUTE_STEP_CYCLES - 8'h01) ? 8'h00 : step_cnt_r + 8'h01;
         case (ramp_r)
            amp_regs_pkg::RAMP_OPEN: begin
               if (mute_req) begin
                  ramp_r <= amp_regs_pkg::RAMP_FADE;
               end
            end
            amp_regs_pkg::RAMP_FADE: begin
               if (!mute_req) begin
                  ramp_r <= amp_regs_pkg::RAMP_RISE;
               end else if (play_atten_o == 4'hf) begin
                  ramp_r       <= amp_regs_pkg::RAMP_SILENT;
                  play_muted_o <= 1'b1;
               end else if (step_cnt_r == 8'h00) begin
                  play_atten_o <= play_atten_o + 4'h1;
               end
            end
            amp_regs_pkg::RAMP_SILENT: begin
               if (!mute_req) begin
                  ramp_r       <= amp_regs_pkg::RAMP_RISE;
                  play_muted_o <= 1'b0;
               end
            end
            amp_regs_pkg::RAMP_RISE: begin
               if (mute_req) begin
                  ramp_r <= amp_regs_pkg::RAMP_FADE;
               end else if (play_atten_o == 4'h0) begin
                  ramp_r <= amp_regs_pkg::RAMP_OPEN;
               end else if (step_cnt_r == 8'h00) begin
                  play_atten_o <= play_atten_o - 4'h1;
               end
            end
            default: ramp_r <= amp_regs_pkg::RAMP_SILENT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded controls, registered

   logic [2:0] pm;
   logic [1:0] ps;
   logic       scheme;

   assign pm     = mode_q[amp_regs_pkg::PATH_MODE_MSB:amp_regs_pkg::PATH_MODE_LSB];
   assign ps     = pwr_q[amp_regs_pkg::PWR_SEL_MSB:amp_regs_pkg::PWR_SEL_LSB];
   assign scheme = spk_q[amp_regs_pkg::RAIL_SCHEME_BIT];

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_o <= '0;
         ctrl_o.path_mode <= amp_regs_pkg::PATH_PCM;
      end else begin
         ctrl_o.path_mode       <= amp_regs_pkg::path_mode_e'(pm);
         ctrl_o.pcm_in          <= pm == 3'h1 || pm == 3'h2 || pm == 3'h3;
         ctrl_o.pdm_in          <= pm == 3'h4 || pm == 3'h5;
         ctrl_o.pcm_sense       <= pm == 3'h2;
         ctrl_o.pdm_sense       <= pm == 3'h3 || pm == 3'h5;
         ctrl_o.powered         <= ps == amp_regs_pkg::PWR_UP_BOOST || ps == amp_regs_pkg::PWR_UP_NOBST;
         ctrl_o.boost_on        <= ps == amp_regs_pkg::PWR_UP_BOOST;
         ctrl_o.boost_track     <= ps == amp_regs_pkg::PWR_UP_BOOST && !scheme;
         ctrl_o.boost_to_max    <= ps == amp_regs_pkg::PWR_UP_BOOST && scheme;
         ctrl_o.boost_off_delay <= spk_q[amp_regs_pkg::OFF_DLY_MSB:amp_regs_pkg::OFF_DLY_LSB];
         ctrl_o.boost_precharge <= spk_q[amp_regs_pkg::PRECHARGE_BIT];
         ctrl_o.dac_gain_db     <= spk_q[amp_regs_pkg::GAIN_MSB:amp_regs_pkg::GAIN_LSB];
         ctrl_o.current_sense_silence <= pwr_q[amp_regs_pkg::ISNS_MUTE_BIT];
         ctrl_o.voltage_sense_silence <= pwr_q[amp_regs_pkg::VSNS_MUTE_BIT];
      end
   end

endmodule

// ==== verif/amp_regs_sva.sv ====
// port-level assertions for the mode and power register bank
`timescale 1ns/1ps
module amp_regs_sva (
   // clock and reset
   input wire logic                    sys_clk_i,
   input wire logic                    rst_i,
   // watched ports
   input wire amp_regs_pkg::reg_req_s  req_i,
   input wire logic [7:0]              rdata_o,
   input wire logic                    rvalid_o,
   input wire logic                    fault_i,
   input wire amp_regs_pkg::amp_ctrl_s ctrl_o,
   input wire logic [3:0]              play_atten_o,
   input wire logic                    play_muted_o,
   input wire logic                    page_auto_increment_o,
   input wire logic [7:0]              page_o,
   input wire logic                    soft_reset_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   // bank writes count only on page zero
   logic bank_wr;
   assign bank_wr = req_i.wr && page_o == amp_regs_pkg::BANK_PAGE;
   // reset request is a single cycle, never a level
   sequence s_one_pulse;
      soft_reset_o ##1 !soft_reset_o;
   endsequence
   sequence s_step_then_hold;
      (play_atten_o - $past(play_atten_o)) inside {4'h1, 4'hf} ##1 $stable(play_atten_o) [*8];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("read not answered");
   a_no_stray: assert property (!req_i.rd |=> !rvalid_o) else $error("stray read valid");
   a_refused_zero: assert property (req_i.rd && page_o != 8'h00 && req_i.addr != 8'h00 |=> rdata_o == 8'h00)
      else $error("off page read not zero");
   a_page_written: assert property (req_i.wr && req_i.addr == 8'h00 |-> ##2 page_o == $past(req_i.wdata, 2))
      else $error("page select not taken");
   a_reset_pulse: assert property (bank_wr && req_i.addr == 8'h02 && req_i.wdata[7] |=> s_one_pulse)
      else $error("reset pulse wrong");
   a_auto_inc_on: assert property (page_auto_increment_o) else $error("auto increment off");
   a_path_follow: assert property (bank_wr && req_i.addr == 8'h02 |-> ##2 ctrl_o.path_mode == $past(req_i.wdata[2:0], 2))
      else $error("path mode not decoded");
   a_gain_follow: assert property (bank_wr && req_i.addr == 8'h04 |-> ##2 ctrl_o.dac_gain_db == $past(req_i.wdata[3:0], 2))
      else $error("gain not decoded");
   a_sense_mutes: assert property (bank_wr && req_i.addr == 8'h07 |-> ##2
      {ctrl_o.current_sense_silence, ctrl_o.voltage_sense_silence} == $past(req_i.wdata[2:1], 2))
      else $error("sense mutes not decoded");
   a_fault_down: assert property ($rose(fault_i) |-> ##2 !ctrl_o.powered) else $error("fault left power on");
   a_atten_step: assert property ($changed(play_atten_o) |-> s_step_then_hold) else $error("ramp step wrong");
   a_muted_full: assert property (play_muted_o |-> play_atten_o == 4'hf) else $error("muted not full");
endmodule
bind amp_mode_power_control_regs amp_regs_sva u_sva (.sys_clk_i, .rst_i, .req_i, .rdata_o, .rvalid_o, .fault_i,
   .ctrl_o, .play_atten_o, .play_muted_o, .page_auto_increment_o, .page_o, .soft_reset_o);

// ==== verif/amp_host_model.sv ====
// host model issuing one register request at a time
`timescale 1ns/1ps
module amp_host_model (
   // clock
   input  wire logic              sys_clk_i,
   // request toward the bank
   output amp_regs_pkg::reg_req_s req_o,
   // read answer
   input  wire logic [7:0]        rdata_i,
   input  wire logic              rvalid_i
);
   initial req_o = '0;
   // idle lines show inverted values so a stale address is never mistaken for live
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk_i);
      req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(negedge sys_clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask
   // answer stands one cycle, taken at the falling edge inside it
   task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(negedge sys_clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(negedge sys_clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
      data = rdata_i;
      ok = rvalid_i;
   endtask
endmodule

// ==== verif/amp_mode_power_control_regs_tb.sv ====
// self-checking bench for the mode and power register bank
`timescale 1ns/1ps
module amp_mode_power_control_regs_tb;
   logic                    sys_clk_i = 1'b0;
   logic                    rst_i = 1'b1;
   logic                    fault_i = 1'b0;
   amp_regs_pkg::reg_req_s  req;
   amp_regs_pkg::amp_ctrl_s ctrl;
   logic [7:0]              rdata, page, rd, w, p;
   logic                    rvalid, muted, auto_inc, soft_rst, ok;
   logic [3:0]              atten;
   int                      fail_count = 0;
   int                      checks = 0;
   integer                  seed = 440;
   int                      n;
   int                      step = amp_regs_pkg::MUTE_STEP_CYCLES;
   always #2.5 sys_clk_i = ~sys_clk_i;
   ////////////////////////////////////////////////////////////////////////
   amp_host_model u_host (.sys_clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
   amp_mode_power_control_regs u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
      .rvalid_o(rvalid), .fault_i(fault_i), .ctrl_o(ctrl), .play_atten_o(atten), .play_muted_o(muted),
      .page_auto_increment_o(auto_inc), .page_o(page), .soft_reset_o(soft_rst));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int c);
      repeat (c) @(negedge sys_clk_i);
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
      u_host.read(a, rd, ok);
      check(ok, 1'b1);
      check(rd, e);
   endtask
   // bounded wait on the playback ramp
   task automatic wait_atten(input logic [3:0] t, output int cnt);
      cnt = 0;
      while (atten !== t && cnt < 2000) begin
         @(negedge sys_clk_i);
         cnt++;
      end
      if (atten !== t) begin
         fail_count++;
         final_report();
      end
   endtask
   // path decode: pcm in, pdm in, pcm sense, pdm sense
   function automatic logic [7:0] exp_path(input int c);
      exp_path = {4'h0, c <= 3, c >= 4, c == 2, c == 3 || c == 5};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      settle(16);
      rst_i <= 1'b0;
      rd_check(8'h02, 8'h01);
      rd_check(8'h04, 8'h5f);
      rd_check(8'h05, 8'h00);
      rd_check(8'h07, 8'h00);
      rd_check(8'h00, 8'h00);
      check(muted, 1'b1);
      // reset request reads back clear
      u_host.write(8'h02, 8'h81);
      check(soft_rst, 1'b1);
      settle(2);
      u_host.read(8'h02, rd, ok);
      check(rd[7], 1'b0);
      check(auto_inc, 1'b1);
      // defined path modes only, reserved codes kept out
      for (int c = 1; c <= 5; c++) begin
         u_host.write(8'h02, 8'(c));
         settle(2);
         check(ctrl.path_mode, 8'(c));
         check({ctrl.pcm_in, ctrl.pdm_in, ctrl.pcm_sense, ctrl.pdm_sense}, exp_path(c));
      end
      // gain corners then random codes
      for (int i = 0; i < 8; i++) begin
         w = $random(seed);
         w[7:5] = 3'h2;
         w[3:0] = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : w[3:0];
         u_host.write(8'h04, w);
         rd_check(8'h04, w);
         check(ctrl.dac_gain_db, w[3:0]);
      end
      // each defined power state under both supply schemes, reserved code kept out
      for (int s = 0; s < 6; s++) begin
         w = {3'h2, 1'(s % 2), 4'h7};
         p = {2'(s / 2), 3'h0, 3'($random(seed))};
         u_host.write(8'h04, w);
         u_host.write(8'h07, p);
         rd_check(8'h07, p);
         check(ctrl.powered, s / 2 != 0);
         check(ctrl.boost_on, s / 2 == 1);
         check({ctrl.current_sense_silence, ctrl.voltage_sense_silence}, p[2:1]);
         if (s / 2 == 1) begin
            check(ctrl.boost_to_max, s % 2 == 1);
            check(ctrl.boost_track, s % 2 == 0);
         end
      end
      // off page accesses refused, then page zero again
      u_host.write(8'h00, 8'h03);
      rd_check(8'h04, 8'h00);
      u_host.write(8'h04, 8'h50);
      rd_check(8'h00, 8'h03);
      check(page, 8'h03);
      u_host.write(8'h00, 8'h00);
      rd_check(8'h04, w);
      rd_check(8'h03, 8'h00);
      // start from full silence so the ramp length is known
      u_host.write(8'h07, 8'h01);
      wait_atten(4'hf, n);
      settle(2);
      // playback unmute ramps down one step per period
      u_host.write(8'h07, 8'h40);
      wait_atten(4'h0, n);
      check(n >= 14 * step && n <= 15 * step + 8, 1'b1);
      settle(2);
      check(muted, 1'b0);
      u_host.write(8'h07, 8'h41);
      wait_atten(4'hf, n);
      settle(2);
      check(muted, 1'b1);
      // fault drops the power field, other bits kept
      u_host.write(8'h07, 8'h46);
      @(negedge sys_clk_i) fault_i <= 1'b1;
      settle(3);
      rd_check(8'h07, 8'h06);
      check(ctrl.powered, 1'b0);
      rd_check(8'h05, 8'h01);
      @(negedge sys_clk_i) fault_i <= 1'b0;
      settle(4);
      // flag clears once the fault is gone and the host writes zero
      u_host.write(8'h05, 8'h00);
      rd_check(8'h05, 8'h00);
      final_report();
   end
endmodule
